/* File: src/pds_pkg.sv */
package pds_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_ERR = 4;

  // word offsets (byte addresses)
  localparam logic [ADDR_W-1:0] DEV_CS_OFFS = 12'h0e8;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFFS = 12'h100;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFS = 12'h104;

  // control half fields
  localparam int EN_LSB = 0;
  localparam int MPS_LSB = 5;
  localparam int MPS_W = 3;
  localparam int AUX_EN_BIT = 10;
  // status half fields
  localparam int DET_LSB = 16;
  localparam int AUX_DET_BIT = 20;

  // error classes, also the bit order of every 4-bit error vector
  localparam int ERR_CORR = 0;
  localparam int ERR_NONFATAL = 1;
  localparam int ERR_FATAL = 2;
  localparam int ERR_UNSUP = 3;

  // byte lanes holding the fields
  localparam int LANE_CTRL_LO = 0;
  localparam int LANE_CTRL_HI = 1;
  localparam int LANE_STAT_LO = 2;

  // reset values and fixed codes
  localparam logic [NUM_ERR-1:0] EN_RESET = 4'h0;
  localparam logic [NUM_ERR-1:0] DET_RESET = 4'h0;
  localparam logic [MPS_W-1:0] MPS_RESET = 3'h0;
  localparam logic [MPS_W-1:0] MPS_SUPPORTED = 3'h0;
  localparam logic AUX_DET_RESET = 1'b1;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNIMPL_MASK = 32'h0020_fb10;
  localparam logic [DATA_W-1:0] RSVD_MASK = 32'hffc0_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // payload limit: never store more than the supported code
  function automatic logic [MPS_W-1:0] clamp_mps(input logic [MPS_W-1:0] v);
    return (v > MPS_SUPPORTED) ? MPS_SUPPORTED : v;
  endfunction
endpackage

/* File: src/pds_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pds_reg_if;
  logic wr_en;
  logic [pds_pkg::ADDR_W-1:0] wr_addr;
  logic [pds_pkg::DATA_W-1:0] wr_data;
  logic [pds_pkg::DATA_W/8-1:0] wr_strb;
  logic wr_err;
  logic [pds_pkg::ADDR_W-1:0] rd_addr;
  logic [pds_pkg::DATA_W-1:0] rd_data;
  logic rd_err;

  // bus front end drives accesses, register file answers
  modport front (output wr_en, output wr_addr, output wr_data,
                 output wr_strb, output rd_addr,
                 input wr_err, input rd_data, input rd_err);
  modport regs (input wr_en, input wr_addr, input wr_data,
                input wr_strb, input rd_addr,
                output wr_err, output rd_data, output rd_err);
endinterface
`default_nettype wire

/* File: src/pds_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module pds_axil_slave (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [pds_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [pds_pkg::DATA_W-1:0] wdata_in,
  input wire logic [pds_pkg::DATA_W/8-1:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [pds_pkg::ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [pds_pkg::DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  pds_reg_if.front rif
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [pds_pkg::ADDR_W-1:0] awaddr_q;
  logic [pds_pkg::DATA_W-1:0] wdata_q, rdata_q;
  logic [pds_pkg::DATA_W/8-1:0] wstrb_q;
  logic aw_take, w_take, ar_take, do_wr;

  assign aw_take = awvalid_in & awready_q;
  assign w_take = wvalid_in & wready_q;
  assign ar_take = arvalid_in & arready_q;
  // both halves held and no response pending: commit this edge
  assign do_wr = ~awready_q & ~wready_q & ~bvalid_q;

  assign rif.wr_en = do_wr;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = araddr_in;

  // write address and data taken in either order
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= pds_pkg::WORD_ZERO;
      wstrb_q <= '0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        awaddr_q <= awaddr_in;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        wdata_q <= wdata_in;
        wstrb_q <= wstrb_in;
      end
      // reopen only once the response is accepted: one write at a time
      if (bvalid_q && bready_in) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= pds_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= rif.wr_err ? pds_pkg::RESP_SLVERR : pds_pkg::RESP_OKAY;
    end else if (bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // read: data registered on the same edge that takes the address
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= pds_pkg::WORD_ZERO;
      rresp_q <= pds_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rif.rd_data;
      rresp_q <= rif.rd_err ? pds_pkg::RESP_SLVERR : pds_pkg::RESP_OKAY;
    end else if (rvalid_q && rready_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
endmodule
`default_nettype wire

/* File: src/pds_dev_ctrl_status.sv */
`timescale 1ns/1ps
`default_nettype none
module pds_dev_ctrl_status #(
  parameter int NUM_ERR = pds_pkg::NUM_ERR
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_rst_n_in,
  input wire logic [pds_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [pds_pkg::DATA_W-1:0] wdata_in,
  input wire logic [pds_pkg::DATA_W/8-1:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [pds_pkg::ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [pds_pkg::DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [NUM_ERR-1:0] err_event_in,
  input wire logic aux_pwr_det_in,
  output logic [NUM_ERR-1:0] err_msg_out,
  output logic [pds_pkg::MPS_W-1:0] max_payload_out,
  output logic aux_pwr_en_out,
  output logic irq_out
);
  pds_reg_if rif ();

  logic [NUM_ERR-1:0] en_q;
  logic [pds_pkg::MPS_W-1:0] mps_q;
  logic aux_en_q;
  logic [NUM_ERR-1:0] det_q, det_d;
  logic aux_det_q;
  logic [NUM_ERR-1:0] msg_q;
  logic [NUM_ERR-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
  logic irq_q;
  logic wr_devcs, wr_istat, wr_imask;
  logic [pds_pkg::DATA_W-1:0] wd;
  logic [pds_pkg::DATA_W/8-1:0] ws;
  logic [NUM_ERR-1:0] det_clr, istat_clr;

  // bus front end
  pds_axil_slave u_bus (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .rif(rif.front)
  );

  // write decode
  assign wd = rif.wr_data;
  assign ws = rif.wr_strb;
  always_comb begin
    wr_devcs = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    rif.wr_err = 1'b0;
    if (rif.wr_addr == pds_pkg::DEV_CS_OFFS) begin
      wr_devcs = rif.wr_en;
    end else if (rif.wr_addr == pds_pkg::IRQ_STAT_OFFS) begin
      wr_istat = rif.wr_en;
    end else if (rif.wr_addr == pds_pkg::IRQ_MASK_OFFS) begin
      wr_imask = rif.wr_en;
    end else begin
      rif.wr_err = 1'b1;
    end
  end

  // reporting enables
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= pds_pkg::EN_RESET;
    end else if (wr_devcs && ws[pds_pkg::LANE_CTRL_LO]) begin
      en_q <= wd[pds_pkg::EN_LSB +: NUM_ERR];
    end
  end

  // payload limit, clamped on write so no illegal code is ever held
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mps_q <= pds_pkg::MPS_RESET;
    end else if (wr_devcs && ws[pds_pkg::LANE_CTRL_LO]) begin
      mps_q <= pds_pkg::clamp_mps(wd[pds_pkg::MPS_LSB +: pds_pkg::MPS_W]);
    end
  end

  // aux power enable: only power-on reset clears it, link reset does not
  always_ff @(posedge clk_in or negedge por_rst_n_in) begin
    if (!por_rst_n_in) begin
      aux_en_q <= 1'b0;
    end else if (rst_n_in && wr_devcs && ws[pds_pkg::LANE_CTRL_HI]) begin
      aux_en_q <= wd[pds_pkg::AUX_EN_BIT];
    end
  end

  // detected flags: set beats a simultaneous write-one clear
  always_comb begin
    det_clr = '0;
    if (wr_devcs && ws[pds_pkg::LANE_STAT_LO]) begin
      det_clr = wd[pds_pkg::DET_LSB +: NUM_ERR];
    end
    det_d = (det_q & ~det_clr) | err_event_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      det_q <= pds_pkg::DET_RESET;
    end else begin
      det_q <= det_d;
    end
  end

  // aux power seen: reads one from reset, then follows the pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_det_q <= pds_pkg::AUX_DET_RESET;
    end else begin
      aux_det_q <= aux_pwr_det_in;
    end
  end

  // upstream error messages, one-cycle pulses gated by the enables
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msg_q <= '0;
    end else begin
      msg_q <= err_event_in & en_q;
    end
  end

  // interrupt status, same error order, write one to clear
  always_comb begin
    istat_clr = '0;
    if (wr_istat && ws[pds_pkg::LANE_CTRL_LO]) begin
      istat_clr = wd[NUM_ERR-1:0];
    end
    irq_stat_d = (irq_stat_q & ~istat_clr) | err_event_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_imask && ws[pds_pkg::LANE_CTRL_LO]) begin
        irq_mask_q <= wd[NUM_ERR-1:0];
      end
      // one cycle behind status, keeps the output straight off a flop
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read mux; unlisted bits stay zero
  always_comb begin
    rif.rd_data = pds_pkg::WORD_ZERO;
    rif.rd_err = 1'b0;
    if (rif.rd_addr == pds_pkg::DEV_CS_OFFS) begin
      rif.rd_data[pds_pkg::EN_LSB +: NUM_ERR] = en_q;
      rif.rd_data[pds_pkg::MPS_LSB +: pds_pkg::MPS_W] = mps_q;
      rif.rd_data[pds_pkg::AUX_EN_BIT] = aux_en_q;
      rif.rd_data[pds_pkg::DET_LSB +: NUM_ERR] = det_q;
      rif.rd_data[pds_pkg::AUX_DET_BIT] = aux_det_q;
    end else if (rif.rd_addr == pds_pkg::IRQ_STAT_OFFS) begin
      rif.rd_data[NUM_ERR-1:0] = irq_stat_q;
    end else if (rif.rd_addr == pds_pkg::IRQ_MASK_OFFS) begin
      rif.rd_data[NUM_ERR-1:0] = irq_mask_q;
    end else begin
      rif.rd_err = 1'b1;
    end
  end

  assign err_msg_out = msg_q;
  assign max_payload_out = mps_q;
  assign aux_pwr_en_out = aux_en_q;
  assign irq_out = irq_q;

  // checks
  // bus handshakes are judged by the bench; these watch the fields
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_ctrl_wr;
    wr_devcs && ws[pds_pkg::LANE_CTRL_LO];
  endsequence

  sequence s_stat_wr;
    wr_devcs && ws[pds_pkg::LANE_STAT_LO];
  endsequence

  sequence s_cs_read;
    rif.rd_addr == pds_pkg::DEV_CS_OFFS;
  endsequence

  property p_en_follows(int b);
    s_ctrl_wr |=> en_q[b] == $past(wd[pds_pkg::EN_LSB + b]);
  endproperty

  property p_det_sets(int b);
    err_event_in[b] |=> det_q[b] ##1 (det_q[b] || $past(det_clr[b]));
  endproperty

  property p_det_clears(int b);
    s_stat_wr ##0 (wd[pds_pkg::DET_LSB + b] && !err_event_in[b])
      |=> !det_q[b];
  endproperty

  a_corr_en_wr: assert property (p_en_follows(pds_pkg::ERR_CORR))
    else $error("correctable enable did not take write");
  a_nonfatal_en_wr: assert property (p_en_follows(pds_pkg::ERR_NONFATAL))
    else $error("non-fatal enable did not take write");
  a_fatal_en_wr: assert property (p_en_follows(pds_pkg::ERR_FATAL))
    else $error("fatal enable did not take write");
  a_unsup_en_wr: assert property (p_en_follows(pds_pkg::ERR_UNSUP))
    else $error("unsupported-request enable did not take write");
  a_en_hold: assert property (
    !(wr_devcs && ws[pds_pkg::LANE_CTRL_LO]) |=> $stable(en_q))
    else $error("reporting enables changed without write");

  a_payload_clamp: assert property (
    s_ctrl_wr |=> mps_q == pds_pkg::clamp_mps($past(
      wd[pds_pkg::MPS_LSB +: pds_pkg::MPS_W])))
    else $error("payload field not clamped on write");
  a_payload_fixed: assert property (
    max_payload_out == pds_pkg::MPS_SUPPORTED)
    else $error("payload field holds unsupported code");

  a_aux_en_wr: assert property (
    wr_devcs && ws[pds_pkg::LANE_CTRL_HI]
      |=> aux_pwr_en_out == $past(wd[pds_pkg::AUX_EN_BIT]))
    else $error("aux power enable did not take write");
  a_aux_en_hold: assert property (
    !(wr_devcs && ws[pds_pkg::LANE_CTRL_HI])
      |=> $stable(aux_en_q) || !por_rst_n_in)
    else $error("aux power enable changed without write");

  a_unimpl_zero: assert property (
    s_cs_read |-> (rif.rd_data & pds_pkg::UNIMPL_MASK) == pds_pkg::WORD_ZERO)
    else $error("unimplemented bit reads nonzero");
  a_rrs_zero: assert property (
    s_cs_read |-> rif.rd_data[15:12] == 4'h0)
    else $error("read request field or bit 15 nonzero");

  a_corr_det_set: assert property (p_det_sets(pds_pkg::ERR_CORR))
    else $error("correctable flag not set");
  a_nonfatal_det_set: assert property (p_det_sets(pds_pkg::ERR_NONFATAL))
    else $error("non-fatal flag not set");
  a_fatal_det_set: assert property (p_det_sets(pds_pkg::ERR_FATAL))
    else $error("fatal flag not set");
  a_unsup_det_set: assert property (p_det_sets(pds_pkg::ERR_UNSUP))
    else $error("unsupported-request flag not set");
  a_corr_det_w1c: assert property (p_det_clears(pds_pkg::ERR_CORR))
    else $error("correctable flag not cleared by one");
  a_fatal_det_w1c: assert property (p_det_clears(pds_pkg::ERR_FATAL))
    else $error("fatal flag not cleared by one");
  // a clear only counts when no event hits the same bit that cycle
  a_nonfatal_det_w1c: assert property (p_det_clears(pds_pkg::ERR_NONFATAL))
    else $error("non-fatal flag not cleared by one");
  a_unsup_det_w1c: assert property (p_det_clears(pds_pkg::ERR_UNSUP))
    else $error("unsupported-request flag not cleared by one");
  a_det_zero_keeps: assert property (
    s_stat_wr |=> (det_q & ~$past(wd[pds_pkg::DET_LSB +: NUM_ERR]))
      == (($past(det_q) | $past(err_event_in))
      & ~$past(wd[pds_pkg::DET_LSB +: NUM_ERR])))
    else $error("writing zero disturbed a flag");

  a_log_when_off: assert property (
    (err_event_in != '0) && (en_q == '0) |=> (det_q & $past(err_event_in))
      == $past(err_event_in))
    else $error("flag not logged with reporting off");

  a_aux_det_track: assert property (
    ##1 aux_det_q == $past(aux_pwr_det_in))
    else $error("aux detected bit does not follow pin");
  a_rsvd_zero: assert property (
    s_cs_read |-> (rif.rd_data & pds_pkg::RSVD_MASK) == pds_pkg::WORD_ZERO)
    else $error("reserved status bits nonzero");

  a_msg_gated: assert property (
    ##1 err_msg_out == ($past(err_event_in) & $past(en_q)))
    else $error("error message not gated by enable");
  a_msg_pulse: assert property (
    (err_event_in == '0) |=> err_msg_out == '0)
    else $error("error message without event");

  // interrupt status mirrors the flags, with its own clear
  a_istat_sets: assert property (
    (err_event_in != '0) |=> (irq_stat_q & $past(err_event_in))
      == $past(err_event_in))
    else $error("interrupt status missed an event");
  a_istat_w1c: assert property (
    wr_istat && ws[pds_pkg::LANE_CTRL_LO] |=> (irq_stat_q
      & $past(wd[NUM_ERR-1:0] & ~err_event_in)) == '0)
    else $error("interrupt status not cleared by one");

  // output lags status by one cycle so it comes straight off a flop
  a_irq_level: assert property (
    ##1 irq_out == $past(|(irq_stat_q & irq_mask_q)))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

/* File: bench/pds_err_source.sv */
`timescale 1ns/1ps
`default_nettype none
// link-side stand-in: raises error events, tallies error messages
module pds_err_source #(
  parameter int NUM_ERR = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic [NUM_ERR-1:0] err_event_out,
  input wire logic [NUM_ERR-1:0] err_msg_in
);
  int msg_cnt [NUM_ERR];

  initial err_event_out = '0;

  // one cycle high per event, launched and dropped just after an edge
  task automatic pulse(input logic [NUM_ERR-1:0] v);
    @(posedge clk_in);
    err_event_out <= v;
    @(posedge clk_in);
    err_event_out <= '0;
  endtask

  // count every message; the bench judges whether it was due
  always @(posedge clk_in) begin
    for (int i = 0; i < NUM_ERR; i++) begin
      if (rst_n_in === 1'b1 && err_msg_in[i] === 1'b1) begin
        msg_cnt[i] <= msg_cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in, rst_n_in, por_rst_n_in;
  logic [pds_pkg::ADDR_W-1:0] awaddr_in, araddr_in;
  logic awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [31:0] wdata_in, rdata_out, rd;
  logic [3:0] wstrb_in, err_event_in, err_msg_out;
  logic [1:0] bresp_out, rresp_out, rsp;
  logic [2:0] max_payload_out;
  logic aux_pwr_det_in, aux_pwr_en_out, irq_out;
  logic [3:0] det;
  int failures, tests_run;

  pds_err_source #(.NUM_ERR(pds_pkg::NUM_ERR)) u_src (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .err_event_out(err_event_in), .err_msg_in(err_msg_out));

  pds_dev_ctrl_status u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .por_rst_n_in(por_rst_n_in),
    .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
    .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in), .wready_out(wready_out),
    .bresp_out(bresp_out), .bvalid_out(bvalid_out),
    .bready_in(bready_in), .araddr_in(araddr_in),
    .arvalid_in(arvalid_in), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out),
    .rvalid_out(rvalid_out), .rready_in(rready_in),
    .err_event_in(err_event_in), .aux_pwr_det_in(aux_pwr_det_in),
    .err_msg_out(err_msg_out), .max_payload_out(max_payload_out),
    .aux_pwr_en_out(aux_pwr_en_out), .irq_out(irq_out));

  // 40 MHz clock
  initial clk_in = 1'b0;
  always #12.5 clk_in = ~clk_in;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what,
               seen, exp);
    end
  endtask

  // expected control/status word; payload is always the supported code
  function automatic logic [31:0] cs_word(input logic [3:0] en,
      input logic aux_en, input logic [3:0] dt, input logic aux_det);
    cs_word = pds_pkg::WORD_ZERO;
    cs_word[pds_pkg::EN_LSB +: 4] = en;
    cs_word[pds_pkg::MPS_LSB +: pds_pkg::MPS_W] = pds_pkg::MPS_SUPPORTED;
    cs_word[pds_pkg::AUX_EN_BIT] = aux_en;
    cs_word[pds_pkg::DET_LSB +: 4] = dt;
    cs_word[pds_pkg::AUX_DET_BIT] = aux_det;
  endfunction

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    r = 2'h3;
    @(posedge clk_in);
    awaddr_in <= a;
    wdata_in <= d;
    wstrb_in <= s;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (awvalid_in && awready_out === 1'b1) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out === 1'b1) wvalid_in <= 1'b0;
      if (bvalid_out === 1'b1) begin
        r = bresp_out;
        bready_in <= 1'b0;
        break;
      end
    end
    chk(32'($isunknown(r)), 32'h0000_0000, "write resp unknown");
  endtask

  task automatic rdw(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    r = 2'h3;
    d = 32'h0000_0000;
    @(posedge clk_in);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arvalid_in && arready_out === 1'b1) arvalid_in <= 1'b0;
      if (rvalid_out === 1'b1) begin
        d = rdata_out;
        r = rresp_out;
        rready_in <= 1'b0;
        break;
      end
    end
    chk(32'($isunknown(r)), 32'h0000_0000, "read resp unknown");
  endtask

  // write and confirm an okay response
  task automatic wok(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    wr(a, d, s, rsp);
    chk(32'(rsp), 32'(pds_pkg::RESP_OKAY), "write resp");
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdw(a, rd, rsp);
    chk(rd, e, "read data");
    chk(32'(rsp), 32'(pds_pkg::RESP_OKAY), "read resp");
  endtask

  // pulse helper for resets, held three cycles
  task automatic reset_pulse(input logic por);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    por_rst_n_in <= ~por;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_rst_n_in <= 1'b1;
  endtask

  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    close_out();
  end

  initial begin
    {rst_n_in, por_rst_n_in, awvalid_in, wvalid_in, bready_in} = '0;
    {arvalid_in, rready_in, awaddr_in, araddr_in, wdata_in} = '0;
    wstrb_in = 4'h0;
    aux_pwr_det_in = 1'b1;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_rst_n_in <= 1'b1;
    // reset state of the control/status word and interrupt registers
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b0, 4'h0, 1'b1));
    rchk(pds_pkg::IRQ_STAT_OFFS, 32'h0000_0000);
    rchk(pds_pkg::IRQ_MASK_OFFS, 32'h0000_0000);
    // all ones: reserved and unimplemented bits stay zero, aux detected bit keeps its one
    wok(pds_pkg::DEV_CS_OFFS, 32'hffff_ffff, 4'hf);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'hf, 1'b1, 4'h0, 1'b1));
    chk(32'(aux_pwr_en_out), 32'h0000_0001, "aux enable out");
    // every payload code clamps to the supported one, one enable at a time
    for (int c = 0; c < 8; c++) begin
      wok(pds_pkg::DEV_CS_OFFS, 32'(c << pds_pkg::MPS_LSB) | 32'(1 << (c % 4)), 4'h3);
      rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'(1 << (c % 4)), 1'b0, 4'h0, 1'b1));
      chk(32'(max_payload_out), 32'(pds_pkg::MPS_SUPPORTED), "payload out");
    end
    // sticky enable outlives link reset, falls only with power-on reset
    wok(pds_pkg::DEV_CS_OFFS, 32'h0000_040f, 4'h3);
    reset_pulse(1'b0);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b1, 4'h0, 1'b1));
    reset_pulse(1'b1);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b0, 4'h0, 1'b1));
    // lane 0 only: aux enable in lane 1 must not move
    wok(pds_pkg::DEV_CS_OFFS, 32'hffff_ffff, 4'h1);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'hf, 1'b0, 4'h0, 1'b1));
    wok(pds_pkg::DEV_CS_OFFS, 32'h0000_0000, 4'h1);
    // events with reporting off: logged, no message, irq masked
    for (int i = 0; i < 4; i++) begin
      u_src.pulse(4'(1 << i));
      repeat (3) @(posedge clk_in);
      det = 4'((1 << (i + 1)) - 1);
      rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b0, det, 1'b1));
      chk(32'(u_src.msg_cnt[i]), 32'h0000_0000, "msg while off");
      chk(32'(irq_out), 32'h0000_0000, "irq masked");
    end
    // zeros leave the flags; a single one clears only its own flag
    wok(pds_pkg::DEV_CS_OFFS, 32'h0000_0000, 4'h4);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b0, 4'hf, 1'b1));
    for (int i = 0; i < 4; i++) begin
      wok(pds_pkg::DEV_CS_OFFS, 32'(1 << (pds_pkg::DET_LSB + i)), 4'h4);
      det = 4'hf << (i + 1);
      rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'h0, 1'b0, det, 1'b1));
    end
    // reporting on: exactly one message per event of that class
    wok(pds_pkg::DEV_CS_OFFS, 32'h0000_000f, 4'h1);
    for (int i = 0; i < 4; i++) begin
      u_src.pulse(4'(1 << i));
      repeat (3) @(posedge clk_in);
      chk(32'(u_src.msg_cnt[i]), 32'h0000_0001, "msg while on");
    end
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'hf, 1'b0, 4'hf, 1'b1));
    // interrupt: clear, mask in class 0 only, raise, clear again
    wok(pds_pkg::IRQ_STAT_OFFS, 32'h0000_000f, 4'h1);
    rchk(pds_pkg::IRQ_STAT_OFFS, 32'h0000_0000);
    wok(pds_pkg::IRQ_MASK_OFFS, 32'h0000_0001, 4'h1);
    rchk(pds_pkg::IRQ_MASK_OFFS, 32'h0000_0001);
    u_src.pulse(4'h4);
    repeat (3) @(posedge clk_in);
    chk(32'(irq_out), 32'h0000_0000, "irq masked class");
    u_src.pulse(4'h1);
    repeat (3) @(posedge clk_in);
    chk(32'(irq_out), 32'h0000_0001, "irq raised");
    rchk(pds_pkg::IRQ_STAT_OFFS, 32'h0000_0005);
    wok(pds_pkg::IRQ_STAT_OFFS, 32'h0000_0001, 4'h1);
    repeat (3) @(posedge clk_in);
    chk(32'(irq_out), 32'h0000_0000, "irq cleared");
    // unmapped offset: error response, data zero, nothing changes
    rdw(12'h0f0, rd, rsp);
    chk(rd, 32'h0000_0000, "unmapped data");
    chk(32'(rsp), 32'(pds_pkg::RESP_SLVERR), "unmapped rd resp");
    wr(12'h0f0, 32'hffff_ffff, 4'hf, rsp);
    chk(32'(rsp), 32'(pds_pkg::RESP_SLVERR), "unmapped wr resp");
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'hf, 1'b0, 4'hf, 1'b1));
    // auxiliary power going away shows in the status half
    @(posedge clk_in);
    aux_pwr_det_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rchk(pds_pkg::DEV_CS_OFFS, cs_word(4'hf, 1'b0, 4'hf, 1'b0));
    close_out();
  end
endmodule
`default_nettype wire
